// ==== mctcc_pkg.sv ====
`default_nettype none
package mctcc_pkg;
  // apb geometry
  localparam int          ADDR_W = 12;
  localparam int          IDX_W  = ADDR_W - 2;
  localparam int          CNT_W  = 16;
  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_RUN    = 10'h060;
  localparam logic [IDX_W-1:0] IDX_SYNC   = 10'h061;
  localparam logic [IDX_W-1:0] IDX_MODE   = 10'h062;
  localparam logic [IDX_W-1:0] IDX_TCTRL  = 10'h064;
  localparam logic [IDX_W-1:0] IDX_PINACT = 10'h065;
  localparam logic [IDX_W-1:0] IDX_IRQEN  = 10'h066;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h067;
  localparam logic [IDX_W-1:0] IDX_CNT    = 10'h068;
  localparam logic [IDX_W-1:0] IDX_GRA    = 10'h069;
  localparam logic [IDX_W-1:0] IDX_GRB    = 10'h06a;
  // reset values
  localparam logic [7:0]       RST_RUN    = 8'h00;
  localparam logic [7:0]       RST_SYNC   = 8'h00;
  localparam logic [7:0]       RST_MODE   = 8'h00;
  localparam logic [7:0]       RST_TCTRL  = 8'h80;
  localparam logic [7:0]       RST_PINACT = 8'h88;
  localparam logic [7:0]       RST_IRQEN  = 8'hf8;
  localparam logic [7:0]       RST_STATUS = 8'hf8;
  localparam logic [CNT_W-1:0] RST_CNT    = 16'h0000;
  localparam logic [CNT_W-1:0] RST_GR     = 16'hffff;
  // writable bits; the rest read as one
  localparam logic [7:0]       TCTRL_RW   = 8'h7f;
  localparam logic [7:0]       PINACT_RW  = 8'h77;
  localparam logic [7:0]       IRQEN_RW   = 8'h07;
  localparam logic [7:0]       STATUS_RW  = 8'h07;
  // field positions
  localparam int TC_PSC_LSB     = 0;
  localparam int TC_EDGE_LSB    = 3;
  localparam int TC_CLR_LSB     = 5;
  localparam int PA_A_LSB       = 0;
  localparam int PA_B_LSB       = 4;
  localparam int MODE_PAIR_LSB  = 4;
  localparam int MODE_PHASE_BIT = 6;
  localparam int FLAG_A         = 0;
  localparam int FLAG_B         = 1;
  localparam int FLAG_OV        = 2;
  // channel roles
  localparam int PHASE_CHANNEL  = 2;
  localparam int PAIR_CH_LO     = 3;
  localparam int PAIR_CH_HI     = 4;
  // codes
  localparam logic [2:0] PSC_DIV8  = 3'h3;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] CLR_NONE  = 2'h0;
  localparam logic [1:0] CLR_GRA   = 2'h1;
  localparam logic [1:0] CLR_GRB   = 2'h2;
  localparam logic [1:0] CLR_SYNC  = 2'h3;
  localparam logic [1:0] PAIR_COMP = 2'h2;
  localparam logic [1:0] PAIR_RSYN = 2'h3;
  localparam logic [1:0] ACT_KEEP  = 2'h0;
  localparam logic [1:0] ACT_LOW   = 2'h1;
  localparam logic [1:0] ACT_HIGH  = 2'h2;
  localparam logic [1:0] ACT_TOGL  = 2'h3;
endpackage : mctcc_pkg
`default_nettype wire

// ==== mctcc_channel.sv ====
`timescale 1ns/1ns
`default_nettype none
module mctcc_channel
  import mctcc_pkg::*;
#(
  parameter int CHANNEL = 0
) (
  // apb slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // timer pins
  input  wire logic              ext_clk_in_a,
  input  wire logic              ext_clk_in_b,
  input  wire logic              ext_clk_in_c,
  input  wire logic              ext_clk_in_d,
  input  wire logic              capture_in_a,
  input  wire logic              capture_in_b,
  output var  logic              compare_out_a,
  output var  logic              compare_out_b,
  // links to the other channels
  input  wire logic              sync_clear_in,
  input  wire logic              sync_load_in,
  input  wire logic [CNT_W-1:0]  sync_load_data,
  output var  logic              sync_clear_out,
  output var  logic              sync_load_out,
  output var  logic [CNT_W-1:0]  sync_load_value,
  // interrupts
  output logic                   match_irq_a,
  output logic                   match_irq_b,
  output logic                   overflow_irq,
  output logic                   irq
);

  if (CHANNEL < 0 || CHANNEL > 7) begin : g_bad_channel
    $error("mctcc_channel: CHANNEL must lie in 0..7");
  end

  logic [7:0]       run_ctrl;
  logic [7:0]       sync_sel;
  logic [7:0]       chan_mode;
  logic [7:0]       timer_ctrl;
  logic [7:0]       pin_action;
  logic [7:0]       irq_en;
  logic [2:0]       flags;
  logic [2:0]       armed;
  logic [CNT_W-1:0] up_counter;
  logic [CNT_W-1:0] general_reg_a;
  logic [CNT_W-1:0] general_reg_b;
  logic [2:0]       prescale_div;
  logic             count_down;
  logic [5:0]       pin_s1;
  logic [5:0]       pin_s2;
  logic [5:0]       pin_s3;
  logic [CNT_W-1:0] next_counter;
  logic             next_dir;
  logic [31:0]      next_rdata;

  // apb decode; one access cycle, no wait states
  wire [IDX_W-1:0] idx      = paddr[ADDR_W-1:2];
  wire             setup    = psel & ~penable;
  wire             acc      = psel & penable;
  wire             wr       = acc & pwrite;
  wire             hit_run  = idx == IDX_RUN;
  wire             hit_sync = idx == IDX_SYNC;
  wire             hit_mode = idx == IDX_MODE;
  wire             hit_tc   = idx == IDX_TCTRL;
  wire             hit_pa   = idx == IDX_PINACT;
  wire             hit_ie   = idx == IDX_IRQEN;
  wire             hit_st   = idx == IDX_STATUS;
  wire             hit_cnt  = idx == IDX_CNT;
  wire             hit_gra  = idx == IDX_GRA;
  wire             hit_grb  = idx == IDX_GRB;
  wire             mapped   = hit_run | hit_sync | hit_mode | hit_tc | hit_pa | hit_ie
                            | hit_st | hit_cnt | hit_gra | hit_grb;
  assign pready  = acc;
  assign pslverr = acc & ~mapped;
  wire             cnt_wr   = wr & hit_cnt;
  wire             gra_wr   = wr & hit_gra;
  wire             grb_wr   = wr & hit_grb;
  wire             st_wr    = wr & hit_st;
  wire             st_rd    = setup & ~pwrite & hit_st;

  // control fields
  wire [2:0] psc       = timer_ctrl[TC_PSC_LSB +: 3];
  wire [1:0] edge_sel  = timer_ctrl[TC_EDGE_LSB +: 2];
  wire [1:0] clr_src   = timer_ctrl[TC_CLR_LSB +: 2];
  wire [2:0] io_a      = pin_action[PA_A_LSB +: 3];
  wire [2:0] io_b      = pin_action[PA_B_LSB +: 3];
  wire [1:0] pair      = chan_mode[MODE_PAIR_LSB +: 2];
  wire       running   = run_ctrl[CHANNEL];
  wire       synced    = sync_sel[CHANNEL];
  wire       phase_mode = (CHANNEL == PHASE_CHANNEL) && chan_mode[MODE_PHASE_BIT];
  wire       pair_ch   = (CHANNEL == PAIR_CH_LO) || (CHANNEL == PAIR_CH_HI);
  wire       pwm_comp  = pair_ch && (pair == PAIR_COMP);
  wire       pwm_rsync = pair_ch && (pair == PAIR_RSYN);
  wire       pwm_on    = pwm_comp | pwm_rsync;

  // pins cross two flops; the third only feeds edge detection
  wire [5:0] pin_raw  = {capture_in_b, capture_in_a, ext_clk_in_d, ext_clk_in_c,
                         ext_clk_in_b, ext_clk_in_a};
  wire [5:0] pin_rise = pin_s2 & ~pin_s3;
  wire [5:0] pin_fall = ~pin_s2 & pin_s3;

  // count clock
  wire [2:0] div_mask = 3'((4'h1 << psc[1:0]) - 4'h1);
  wire       int_tick = ~psc[2] & ((prescale_div & div_mask) == div_mask);
  wire       ext_r    = pin_rise[psc[1:0]];
  wire       ext_f    = pin_fall[psc[1:0]];
  wire       ext_edge = edge_sel[1] ? (ext_r | ext_f) : (edge_sel[0] ? ext_f : ext_r);
  wire       sel_tick = psc[2] ? ext_edge : int_tick;
  // quadrature: a leads b counts up
  wire       qa       = pin_s2[0];
  wire       qb       = pin_s2[1];
  wire       phase_up = (pin_rise[0] & ~qb) | (pin_fall[0] & qb)
                      | (pin_rise[1] & qa) | (pin_fall[1] & ~qa);
  wire       phase_any = pin_rise[0] | pin_fall[0] | pin_rise[1] | pin_fall[1];
  wire       phase_dn = phase_any & ~phase_up;
  wire       cnt_tick = running & (phase_mode ? phase_any : sel_tick);
  wire       down_now = phase_mode ? phase_dn : (pwm_comp & count_down);

  // compare and capture
  wire       cmp_a    = pwm_on | ~io_a[2];
  wire       cmp_b    = pwm_on | ~io_b[2];
  wire       match_a  = cmp_a & cnt_tick & (up_counter == general_reg_a);
  wire       match_b  = cmp_b & cnt_tick & (up_counter == general_reg_b);
  wire       capedge_a = io_a[1] ? (pin_rise[4] | pin_fall[4])
                       : (io_a[0] ? pin_fall[4] : pin_rise[4]);
  wire       capedge_b = io_b[1] ? (pin_rise[5] | pin_fall[5])
                       : (io_b[0] ? pin_fall[5] : pin_rise[5]);
  wire       cap_a    = ~cmp_a & capedge_a;
  wire       cap_b    = ~cmp_b & capedge_b;
  wire       event_a  = match_a | cap_a;
  wire       event_b  = match_b | cap_b;

  // clearing; complementary pwm reverses instead of clearing on its own events, but a sync clear still clears it
  wire       own_clear = ~pwm_comp & (((clr_src == CLR_GRA) & event_a)
                       | ((clr_src == CLR_GRB) & event_b) | (pwm_rsync & match_a));
  wire       sync_clr = synced & (clr_src == CLR_SYNC) & sync_clear_in;
  wire       sync_ld  = synced & sync_load_in;
  wire       clr_any  = own_clear | sync_clr;
  wire       overflow = cnt_tick & ~down_now & (&up_counter) & ~clr_any;
  wire       pwm_level = up_counter < general_reg_b;

  // a register write beats a preset, which beats a clear, which beats a count
  always_comb begin
    next_dir = count_down;
    if (pwm_comp & cnt_tick) begin
      if (~count_down & (up_counter == general_reg_a)) begin
        next_dir = 1'b1;
      end else if (count_down & (up_counter == RST_CNT)) begin
        next_dir = 1'b0;
      end
    end
    if (cnt_wr) begin
      next_counter = pwdata[CNT_W-1:0];
    end else if (sync_ld) begin
      next_counter = sync_load_data;
    end else if (clr_any) begin
      next_counter = RST_CNT;
    end else if (cnt_tick) begin
      next_counter = (pwm_comp ? next_dir : down_now) ? up_counter - 16'h0001
                                                      : up_counter + 16'h0001;
    end else begin
      next_counter = up_counter;
    end
  end

  // read side effect arms the clear; a write of one never clears
  wire [2:0] hw_set    = {overflow, event_b, event_a};
  wire [2:0] flag_clr  = {3{st_wr}} & armed & ~pwdata[2:0];
  wire [2:0] next_flags = (flags & ~flag_clr) | hw_set;

  function automatic logic pin_act(input logic [1:0] code, input logic cur);
    case (code)
      ACT_KEEP: pin_act = cur;
      ACT_LOW:  pin_act = 1'b0;
      ACT_HIGH: pin_act = 1'b1;
      ACT_TOGL: pin_act = ~cur;
      default:  pin_act = cur;
    endcase
  endfunction : pin_act

  always_comb begin
    case (idx)
      IDX_RUN:    next_rdata = {24'h000000, run_ctrl};
      IDX_SYNC:   next_rdata = {24'h000000, sync_sel};
      IDX_MODE:   next_rdata = {24'h000000, chan_mode};
      IDX_TCTRL:  next_rdata = {24'h000000, timer_ctrl};
      IDX_PINACT: next_rdata = {24'h000000, pin_action};
      IDX_IRQEN:  next_rdata = {24'h000000, irq_en};
      IDX_STATUS: next_rdata = {24'h000000, ~STATUS_RW | {5'h00, flags}};
      IDX_CNT:    next_rdata = {16'h0000, up_counter};
      IDX_GRA:    next_rdata = {16'h0000, general_reg_a};
      IDX_GRB:    next_rdata = {16'h0000, general_reg_b};
      default:    next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 6'h00;
      pin_s2 <= 6'h00;
      pin_s3 <= 6'h00;
      prescale_div <= 3'h0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      prescale_div <= prescale_div + 3'h1;
    end
  end

  // control registers; reserved bits are forced to one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_ctrl   <= RST_RUN;
      sync_sel   <= RST_SYNC;
      chan_mode  <= RST_MODE;
      timer_ctrl <= RST_TCTRL;
      pin_action <= RST_PINACT;
      irq_en     <= RST_IRQEN;
      prdata     <= 32'h00000000;
    end else begin
      if (wr & hit_run)  run_ctrl  <= pwdata[7:0];
      if (wr & hit_sync) sync_sel  <= pwdata[7:0];
      if (wr & hit_mode) chan_mode <= pwdata[7:0];
      if (wr & hit_tc)   timer_ctrl <= (pwdata[7:0] & TCTRL_RW) | ~TCTRL_RW;
      if (wr & hit_pa)   pin_action <= (pwdata[7:0] & PINACT_RW) | ~PINACT_RW;
      if (wr & hit_ie)   irq_en     <= (pwdata[7:0] & IRQEN_RW) | ~IRQEN_RW;
      if (setup & ~pwrite) prdata <= next_rdata;
    end
  end

  // counter, general registers and flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_counter    <= RST_CNT;
      count_down    <= 1'b0;
      general_reg_a <= RST_GR;
      general_reg_b <= RST_GR;
      flags         <= 3'h0;
      armed         <= 3'h0;
    end else begin
      up_counter <= next_counter;
      count_down <= pwm_comp & next_dir;
      if (gra_wr) general_reg_a <= pwdata[CNT_W-1:0];
      else if (cap_a) general_reg_a <= up_counter;
      if (grb_wr) general_reg_b <= pwdata[CNT_W-1:0];
      else if (cap_b) general_reg_b <= up_counter;
      flags <= next_flags;
      if (st_rd) armed <= flags;
      else if (st_wr) armed <= 3'h0;
    end
  end

  // pin outputs and sync links; pwm mode overrides the compare actions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_out_a   <= 1'b0;
      compare_out_b   <= 1'b0;
      sync_clear_out  <= 1'b0;
      sync_load_out   <= 1'b0;
      sync_load_value <= RST_CNT;
    end else begin
      if (pwm_on) begin
        compare_out_a <= pwm_level;
        compare_out_b <= ~pwm_level;
      end else begin
        if (match_a) compare_out_a <= pin_act(io_a[1:0], compare_out_a);
        if (match_b) compare_out_b <= pin_act(io_b[1:0], compare_out_b);
      end
      sync_clear_out <= synced & own_clear;
      sync_load_out  <= synced & cnt_wr;
      if (cnt_wr) sync_load_value <= pwdata[CNT_W-1:0];
    end
  end

  assign match_irq_a  = flags[FLAG_A] & irq_en[FLAG_A];
  assign match_irq_b  = flags[FLAG_B] & irq_en[FLAG_B];
  assign overflow_irq = flags[FLAG_OV] & irq_en[FLAG_OV];
  assign irq          = match_irq_a | match_irq_b | overflow_irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_phase_up_count: assert property (
    (phase_mode && running && phase_up && !cnt_wr && !sync_ld && !clr_any)
      |=> up_counter == 16'($past(up_counter) + 16'h0001))
    else $error("phase counting did not step up");
  chk_pair_pwm_outs: assert property (
    pwm_on ##1 pwm_on |-> compare_out_b != compare_out_a)
    else $error("pwm pair outputs not complementary");
  chk_div8_spacing: assert property (
    (cnt_tick && psc == PSC_DIV8 && !phase_mode)
      |=> (!cnt_tick || psc != PSC_DIV8)[*7])
    else $error("divide-by-8 tick spacing wrong");
  chk_rise_only: assert property (
    (psc[2] && !phase_mode && edge_sel == EDGE_RISE && ext_f) |-> !cnt_tick)
    else $error("falling edge counted in rising mode");
  chk_clear_gra: assert property (
    (clr_src == CLR_GRA && event_a && !pwm_comp && !cnt_wr && !sync_ld)
      |=> up_counter == RST_CNT)
    else $error("counter not cleared by register a event");
  chk_sync_clear: assert property (
    (sync_clr && !cnt_wr && !sync_ld) |=> up_counter == RST_CNT)
    else $error("synchronous clear missed");
  chk_cmp_high_a: assert property (
    (match_a && !pwm_on && io_a == {1'b0, ACT_HIGH}) |=> compare_out_a)
    else $error("compare a did not drive one");
  chk_capture_a: assert property (
    (cap_a && !gra_wr) |=> general_reg_a == $past(up_counter))
    else $error("capture a lost counter value");
  chk_irq_a_gate: assert property (
    $rose(flags[FLAG_A]) |-> match_irq_a == irq_en[FLAG_A])
    else $error("match a request not gated by enable");
  chk_overflow_flag: assert property (
    overflow |=> flags[FLAG_OV] && (up_counter == RST_CNT || $past(cnt_wr || sync_ld)))
    else $error("overflow not flagged");
  chk_write_one_keeps: assert property (
    (st_wr && pwdata[FLAG_A] && flags[FLAG_A]) |=> flags[FLAG_A])
    else $error("write of one cleared a flag");
  chk_stopped_holds: assert property (
    (!running && !cnt_wr && !sync_ld && !clr_any) |=> $stable(up_counter))
    else $error("stopped counter moved");

endmodule : mctcc_channel
`default_nettype wire

// ==== tb_mctcc_channel.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb_mctcc_channel;
  import mctcc_pkg::*;
  logic              pclk    = 1'b0;
  logic              presetn = 1'b0;
  logic              psel    = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite  = 1'b0;
  logic [ADDR_W-1:0] paddr   = '0;
  logic [31:0]       pwdata  = '0;
  logic [3:0]        ext     = 4'h0;
  logic              cap_a   = 1'b0;
  logic              cap_b   = 1'b0;
  logic              sclr    = 1'b0;
  logic              sload   = 1'b0;
  logic [CNT_W-1:0]  sdata   = 16'h0000;
  wire  [31:0]       prdata;
  wire               pready, pslverr, compare_out_a, compare_out_b;
  wire               sync_clear_out, sync_load_out, match_irq_a, match_irq_b, overflow_irq, irq;
  wire  [CNT_W-1:0]  sync_load_value;
  wire  [31:0]       rd_ph, rd_pw;
  wire               pw_a, pw_b;
  int                miscompares = 0;
  int                comparisons = 0;
  int                n;
  logic [31:0]       rd;
  logic              er;
  // tctrl code, pulsed pin, expected count
  localparam logic [7:0]  EXT_TC [7] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h05, 8'h0c, 8'h17};
  localparam int          EXT_PIN [7] = '{0, 1, 2, 3, 0, 0, 3};
  localparam logic [15:0] EXT_N [7] = '{16'h5, 16'h5, 16'h5, 16'h5, 16'h0, 16'h5, 16'ha};

  always #50 pclk = ~pclk;

  mctcc_channel #(.CHANNEL(0)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clk_in_a(ext[0]), .ext_clk_in_b(ext[1]), .ext_clk_in_c(ext[2]),
    .ext_clk_in_d(ext[3]), .capture_in_a(cap_a), .capture_in_b(cap_b),
    .compare_out_a(compare_out_a), .compare_out_b(compare_out_b),
    .sync_clear_in(sclr), .sync_load_in(sload), .sync_load_data(sdata),
    .sync_clear_out(sync_clear_out), .sync_load_out(sync_load_out),
    .sync_load_value(sync_load_value), .match_irq_a(match_irq_a),
    .match_irq_b(match_irq_b), .overflow_irq(overflow_irq), .irq(irq)
  );

  // phase and pair channels share the bus and pins; they run only on their own start bit
  mctcc_channel #(.CHANNEL(PHASE_CHANNEL)) i_ph (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(rd_ph), .pready(), .pslverr(),
    .ext_clk_in_a(ext[0]), .ext_clk_in_b(ext[1]), .ext_clk_in_c(ext[2]),
    .ext_clk_in_d(ext[3]), .capture_in_a(cap_a), .capture_in_b(cap_b),
    .compare_out_a(), .compare_out_b(), .sync_clear_in(sclr), .sync_load_in(sload),
    .sync_load_data(sdata), .sync_clear_out(), .sync_load_out(), .sync_load_value(),
    .match_irq_a(), .match_irq_b(), .overflow_irq(), .irq()
  );

  mctcc_channel #(.CHANNEL(PAIR_CH_LO)) i_pw (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(rd_pw), .pready(), .pslverr(),
    .ext_clk_in_a(ext[0]), .ext_clk_in_b(ext[1]), .ext_clk_in_c(ext[2]),
    .ext_clk_in_d(ext[3]), .capture_in_a(cap_a), .capture_in_b(cap_b),
    .compare_out_a(pw_a), .compare_out_b(pw_b), .sync_clear_in(sclr), .sync_load_in(sload),
    .sync_load_data(sdata), .sync_clear_out(), .sync_load_out(), .sync_load_value(),
    .match_irq_a(), .match_irq_b(), .overflow_irq(), .irq()
  );

  task wrap_up;
    if (miscompares == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // the master waits at most 20 cycles for pready and counts a timeout as a miscompare
  task apb(input logic w, input logic [IDX_W-1:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {a, 2'h0}; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
    if (k >= 20) miscompares++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task wr(input logic [IDX_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rchk(input logic [IDX_W-1:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rchk

  task t_regs;
    rchk(IDX_RUN, 32'(RST_RUN));
    rchk(IDX_SYNC, 32'(RST_SYNC));
    rchk(IDX_TCTRL, 32'(RST_TCTRL));
    rchk(IDX_PINACT, 32'(RST_PINACT));
    rchk(IDX_IRQEN, 32'(RST_IRQEN));
    rchk(IDX_STATUS, 32'(RST_STATUS));
    rchk(IDX_CNT, 32'(RST_CNT));
    rchk(IDX_GRA, 32'(RST_GR));
    rchk(IDX_GRB, 32'(RST_GR));
    apb(1'b0, 10'h063, 32'h0);
    `CHK({er, rd}, 33'h100000000)
    wr(IDX_IRQEN, 32'hff);
    rchk(IDX_IRQEN, 32'hff);
    wr(IDX_IRQEN, 32'h00);
    rchk(IDX_IRQEN, 32'hf8);
    wr(IDX_PINACT, 32'h00);
    rchk(IDX_PINACT, 32'h88);
    wr(IDX_STATUS, 32'hff);
    rchk(IDX_STATUS, 32'hf8);
  endtask : t_regs

  // gra 0x10 and grb 0x20: in the b case register a matches on the way up with its pin kept
  task t_match(input logic b, input logic [1:0] code, input logic exp);
    logic [31:0] c;
    wr(IDX_CNT, 32'h0);
    wr(IDX_PINACT, b ? 32'(code) << PA_B_LSB : 32'(code));
    wr(IDX_TCTRL, 32'(b ? CLR_GRB : CLR_GRA) << TC_CLR_LSB);
    wr(IDX_IRQEN, 32'h1 << (b ? FLAG_B : FLAG_A));
    wr(IDX_RUN, 32'h1);
    n = 0;
    while ((b ? match_irq_b : match_irq_a) !== 1'b1 && n < 100) begin @(posedge pclk); n++; end
    wr(IDX_RUN, 32'h0);
    `CHK(b ? compare_out_b : compare_out_a, exp)
    `CHK(match_irq_a, ~b)
    `CHK(irq, 1'b1)
    apb(1'b0, IDX_CNT, 32'h0);
    c = rd;
    `CHK(c < 32'h10, 1'b1)
    rchk(IDX_CNT, c);
    rchk(IDX_STATUS, b ? 32'hfb : 32'hf9);
    wr(IDX_STATUS, 32'hff);
    rchk(IDX_STATUS, b ? 32'hfb : 32'hf9);
    wr(IDX_STATUS, 32'hf8);
    rchk(IDX_STATUS, 32'hf8);
    `CHK(irq, 1'b0)
  endtask : t_match

  task t_ovf;
    wr(IDX_CNT, 32'hfff0);
    wr(IDX_TCTRL, 32'h0);
    wr(IDX_IRQEN, 32'h4);
    wr(IDX_RUN, 32'h1);
    n = 0;
    while (overflow_irq !== 1'b1 && n < 100) begin @(posedge pclk); n++; end
    wr(IDX_RUN, 32'h0);
    `CHK(overflow_irq, 1'b1)
    apb(1'b0, IDX_CNT, 32'h0);
    `CHK(rd < 32'h10, 1'b1)
    wr(IDX_STATUS, 32'hf8);
    rchk(IDX_STATUS, 32'hfc);
    wr(IDX_STATUS, 32'hf8);
    rchk(IDX_STATUS, 32'hf8);
    `CHK(irq, 1'b0)
  endtask : t_ovf

  // pulses are slow against the pin synchronisers so none is lost
  task t_ext;
    for (int i = 0; i < 7; i++) begin
      wr(IDX_TCTRL, 32'(EXT_TC[i]));
      wr(IDX_CNT, 32'h0);
      wr(IDX_RUN, 32'h1);
      repeat (5) begin
        @(posedge pclk) ext[EXT_PIN[i]] <= 1'b1;
        repeat (4) @(posedge pclk);
        ext[EXT_PIN[i]] <= 1'b0;
        repeat (3) @(posedge pclk);
      end
      repeat (6) @(posedge pclk);
      wr(IDX_RUN, 32'h0);
      rchk(IDX_CNT, 32'(EXT_N[i]));
    end
  endtask : t_ext

  task t_sync;
    wr(IDX_SYNC, 32'h1);
    for (int j = 0; j < 2; j++) begin
      wr(IDX_TCTRL, j ? 32'h05 : 32'h65);
      wr(IDX_CNT, 32'h55);
      @(negedge pclk);
      `CHK(sync_load_out, 1'b1)
      wr(IDX_RUN, 32'h1);
      `CHK(sync_load_value, 16'h0055)
      @(posedge pclk) sclr <= 1'b1;
      @(posedge pclk) sclr <= 1'b0;
      repeat (2) @(posedge pclk);
      wr(IDX_RUN, 32'h0);
      rchk(IDX_CNT, j ? 32'h55 : 32'h0);
    end
    // a preset from another channel reaches only synchronised channels
    @(posedge pclk) sload <= 1'b1;
    sdata <= 16'h0077;
    @(posedge pclk) sload <= 1'b0;
    rchk(IDX_CNT, 32'h77);
    `CHK(rd_ph, 32'h55)
    wr(IDX_TCTRL, 32'(CLR_GRA) << TC_CLR_LSB);
    wr(IDX_CNT, 32'he);
    wr(IDX_RUN, 32'h1);
    n = 0;
    while (sync_clear_out !== 1'b1 && n < 40) begin @(posedge pclk); n++; end
    wr(IDX_RUN, 32'h0);
    `CHK(n < 40, 1'b1)
    rchk(IDX_STATUS, 32'hf9);
    wr(IDX_STATUS, 32'hf8);
    wr(IDX_SYNC, 32'h0);
  endtask : t_sync

  // counter is stopped, so the captured value is known exactly
  task t_cap;
    wr(IDX_IRQEN, 32'h0);
    wr(IDX_TCTRL, 32'h05);
    wr(IDX_PINACT, 32'h40);
    wr(IDX_CNT, 32'h1234);
    @(posedge pclk) cap_b <= 1'b1;
    repeat (6) @(posedge pclk);
    rchk(IDX_GRB, 32'h1234);
    rchk(IDX_STATUS, 32'hfa);
    `CHK(match_irq_b, 1'b0)
    wr(IDX_IRQEN, 32'h2);
    @(posedge pclk);
    `CHK({match_irq_b, irq}, 2'b11)
    wr(IDX_PINACT, 32'h54);
    wr(IDX_CNT, 32'h4321);
    @(posedge pclk) cap_b <= 1'b0;
    cap_a <= 1'b1;
    repeat (6) @(posedge pclk);
    rchk(IDX_GRA, 32'h4321);
    rchk(IDX_GRB, 32'h4321);
    wr(IDX_PINACT, 32'h66);
    wr(IDX_CNT, 32'h0abc);
    @(posedge pclk) cap_b <= 1'b1;
    cap_a <= 1'b0;
    repeat (6) @(posedge pclk);
    rchk(IDX_GRA, 32'h0abc);
    rchk(IDX_GRB, 32'h0abc);
  endtask : t_cap

  // a leading b steps the phase channel up, b leading a steps it down
  task t_phase;
    wr(IDX_MODE, 32'h1 << MODE_PHASE_BIT);
    wr(IDX_TCTRL, 32'h0);
    wr(IDX_CNT, 32'h0);
    wr(IDX_RUN, 32'h1 << PHASE_CHANNEL);
    for (int s = 0; s < 8; s++) begin
      @(posedge pclk) ext[s < 4 ? s % 2 : 1 - s % 2] <= (s % 4) < 2;
      repeat (4) @(posedge pclk);
      if (s == 3) begin
        apb(1'b0, IDX_CNT, 32'h0);
        `CHK(rd_ph, 32'h4)
      end
    end
    wr(IDX_RUN, 32'h0);
    apb(1'b0, IDX_CNT, 32'h0);
    `CHK({rd_ph, rd}, 64'h0)
    wr(IDX_MODE, 32'h0);
    wr(IDX_TCTRL, 32'(PSC_DIV8));
    wr(IDX_RUN, 32'h1 << PHASE_CHANNEL);
    repeat (40) @(posedge pclk);
    wr(IDX_RUN, 32'h0);
    apb(1'b0, IDX_CNT, 32'h0);
    `CHK(rd_ph > 32'h3 && rd_ph < 32'h7, 1'b1)
  endtask : t_phase

  // reset-sync wraps at register a, complementary turns back below it
  task t_pwm;
    wr(IDX_GRA, 32'h10);
    wr(IDX_GRB, 32'h8);
    wr(IDX_TCTRL, 32'h0);
    wr(IDX_MODE, 32'(PAIR_RSYN) << MODE_PAIR_LSB);
    wr(IDX_CNT, 32'h3);
    repeat (2) @(posedge pclk);
    `CHK({pw_a, pw_b}, 2'b10)
    wr(IDX_CNT, 32'h9);
    repeat (2) @(posedge pclk);
    `CHK({pw_a, pw_b}, 2'b01)
    for (int m = 0; m < 2; m++) begin
      wr(IDX_MODE, 32'(m ? PAIR_COMP : PAIR_RSYN) << MODE_PAIR_LSB);
      wr(IDX_CNT, 32'h10);
      wr(IDX_RUN, 32'h1 << PAIR_CH_LO);
      wr(IDX_RUN, 32'h0);
      apb(1'b0, IDX_CNT, 32'h0);
      `CHK(m ? (rd_pw > 32'h8 && rd_pw < 32'h10) : rd_pw < 32'h8, 1'b1)
    end
    wr(IDX_MODE, 32'h0);
  endtask : t_pwm

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    wr(IDX_GRA, 32'h10);
    wr(IDX_GRB, 32'h20);
    t_match(1'b0, ACT_HIGH, 1'b1);
    t_match(1'b0, ACT_LOW, 1'b0);
    t_match(1'b0, ACT_TOGL, 1'b1);
    t_match(1'b0, ACT_KEEP, 1'b1);
    t_match(1'b1, ACT_TOGL, 1'b1);
    t_match(1'b1, ACT_KEEP, 1'b1);
    t_match(1'b1, ACT_LOW, 1'b0);
    t_match(1'b1, ACT_HIGH, 1'b1);
    t_ovf;
    t_ext;
    t_sync;
    t_cap;
    t_phase;
    t_pwm;
    wrap_up;
  end

  // the whole run needs under two thousand cycles
  initial begin
    #2000000;
    miscompares++;
    wrap_up;
  end
endmodule : tb_mctcc_channel
`default_nettype wire
